// ==== rtl/rsfs_pkg.sv ====
package rsfs_pkg;

  // ==========================================================
  // Widths and reference encoding
  // ==========================================================
  localparam int CODE_W = 8;
  localparam int REF_W = 8;
  localparam int PHASES = 4;
  // Reference is in 6.25 mV steps
  localparam logic [REF_W-1:0] REF_ZERO = 8'h00;
  localparam logic [REF_W-1:0] REF_BOOT = 8'had;     // 1.081 V
  localparam logic [REF_W-1:0] REF_UV_ARM = 8'h50;   // 0.5 V
  localparam logic [REF_W-1:0] REF_STEP = 8'h01;     // One LSB
  localparam logic [CODE_W-1:0] CODE_OFF = 8'h00;    // Off code

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_MHZ = 100;
  localparam int DELAY_MS = 2;                       // Initial wait
  localparam int DELAY_CYC = DELAY_MS * 1000 * CLK_MHZ;
  localparam int HOLD_US = 200;                      // Code-reading hold
  localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
  localparam int STEP_CLK_MHZ = 1;                   // Step clock rate
  localparam int STEP_HALF_CYC = CLK_MHZ / (2 * STEP_CLK_MHZ);
  localparam int MASK_CYC = 16;                      // Guard re-arm delay
  localparam int SS_NS_PER_KOHM = 18520;             // Ramp gain
  localparam int RSS_KOHM = 27;                      // Default resistor
  localparam int SS_TOTAL_NS = SS_NS_PER_KOHM * RSS_KOHM;
  // Cycles per reference LSB during soft-start ramp to boot level
  localparam int SS_STEP_CYC = (SS_TOTAL_NS / 10) / 173;

  typedef enum logic [2:0] {
    RSFS_OFF,
    RSFS_WAIT,
    RSFS_RAMP_BOOT,
    RSFS_HOLD,
    RSFS_RAMP_CODE,
    RSFS_RUN,
    RSFS_LATCH
  } rsfs_state_e;

  // Latched fault outcome
  typedef enum logic [1:0] {
    RSFS_FLT_NONE,
    RSFS_FLT_OV,
    RSFS_FLT_HIZ
  } rsfs_fault_e;

endpackage

// ==== rtl/rsfs_sequencer.sv ====
`timescale 1ns/1ps
// What this block does
// R1 - Mask guards in transitions, re-arm after 16
// R2 - Sample code on step rise, confirm falling
// R3 - Then step one LSB per two step cycles
// R4 - Multi-step changes walk at half step-clock rate
// R5 - Overcurrent during transition latches disabled
// R6 - Start only with supplies good and enabled
// R7 - Wait at least 2 ms first
// R8 - Ramp to boot level, hold reading code
// R9 - Ramp boot to programmed level, same slope
// R10 - Ramp down when code below boot
// R11 - Ramp time follows soft-start resistor, configurable
// R12 - Undervoltage from 0.5 V; overvoltage fixed first
// R13 - Off code at hold end: boot, latch
// R14 - No code-line pulls before hold
// R15 - Release power-good after soft-start completes
// R16 - Phases high-Z, drivers off until first pulse
// R17 - Overvoltage may still force low sides
// R18 - Overvoltage armed when supply good and enabled
// R19 - Overvoltage: phases low, drivers on, fault
// R20 - Undervoltage handled like overvoltage
// R21 - Restart only after power or enable cycle
// R22 - Sense-negative disconnection latches high-Z with fault
// R23 - Ground amplifier disconnection latches high-Z, fault
// R24 - Synchronise comparator flags before use
// R25 - Current limit latches overcurrent high-Z
module rsfs_sequencer #(
  parameter int DELAY_CYCLES = rsfs_pkg::DELAY_CYC,
  parameter int HOLD_CYCLES = rsfs_pkg::HOLD_CYC,
  parameter int SS_STEP_CYCLES = rsfs_pkg::SS_STEP_CYC
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic supply_good_in,
  input wire logic enable_in,
  input wire logic [rsfs_pkg::CODE_W-1:0] voltage_code_in,
  input wire logic [rsfs_pkg::PHASES-1:0] pwm_in,
  input wire logic ov_fixed_cmp_in,
  input wire logic ov_code_cmp_in,
  input wire logic uv_cmp_in,
  input wire logic current_limit_cmp_in,
  input wire logic sense_neg_disc_cmp_in,
  input wire logic gnd_amp_disc_cmp_in,
  output logic [rsfs_pkg::PHASES-1:0] phase_modulation_output_out,
  output logic [rsfs_pkg::PHASES-1:0] phase_modulation_oe_out,
  output logic driver_enable_output_out,
  output logic fault_output_out,
  output logic power_good_oe_out,
  output logic code_pull_enable_out,
  output logic dynamic_code_transition_out,
  output logic [rsfs_pkg::REF_W-1:0] reference_out
);
  import rsfs_pkg::*;

  localparam int CNT_W = 32;
  localparam int NSYNC = 8;

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [CODE_W-1:0] code_s1;
    logic [CODE_W-1:0] code_s2;
    rsfs_state_e state;
    logic [CNT_W-1:0] cnt;
    logic [7:0] step_div;
    logic step_clk;
    logic [CODE_W-1:0] code_cur;
    logic [CODE_W-1:0] code_cand;
    logic cand_valid;
    logic stepping;
    logic step_phase;
    logic [4:0] mask_cnt;
    logic ov_armed;
    logic uv_armed;
    logic boot_reached;
    logic switching;
    logic off_latch;
    logic [REF_W-1:0] ref_v;
    rsfs_fault_e fault;
    logic [PHASES-1:0] ph_out;
    logic [PHASES-1:0] ph_oe;
    logic drv_en;
    logic fault_output;
    logic pg_oe;
    logic pull;
    logic dynamic_code_transition;
  } rsfs_state_s;

  rsfs_state_s st_r;
  rsfs_state_s st_nxt;

  logic supply_s;
  logic enable_s;
  logic ov_fix_s;
  logic ov_code_s;
  logic uv_s;
  logic oc_s;
  logic sn_s;
  logic gnd_s;
  logic step_rise;
  logic step_fall;
  logic [REF_W-1:0] target;
  logic ss_tick;
  logic ov_hit;
  logic uv_hit;
  logic hiz_hit;

  // Synchronised flags from the second flop stage only
  assign supply_s = st_r.sync2[0];
  assign enable_s = st_r.sync2[1];
  assign ov_fix_s = st_r.sync2[2];
  assign ov_code_s = st_r.sync2[3];
  assign uv_s = st_r.sync2[4];
  assign oc_s = st_r.sync2[5];
  assign sn_s = st_r.sync2[6];
  assign gnd_s = st_r.sync2[7];

  // Code maps one to one onto reference steps
  assign target = REF_W'(st_r.code_cur);

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb
  begin
    st_nxt = st_r;
    // Two-flop synchronisers for pins and comparators
    st_nxt.sync1 = {gnd_amp_disc_cmp_in, sense_neg_disc_cmp_in, current_limit_cmp_in,
                    uv_cmp_in, ov_code_cmp_in, ov_fixed_cmp_in, enable_in,
                    supply_good_in}; // see R24
    st_nxt.sync2 = st_r.sync1; // see R24
    st_nxt.code_s1 = voltage_code_in;
    st_nxt.code_s2 = st_r.code_s1;

    // Step clock divider: 1 MHz square wave as edge enables
    step_rise = 1'b0;
    step_fall = 1'b0;
    if (st_r.step_div == 8'(STEP_HALF_CYC - 1))
    begin
      st_nxt.step_div = 8'h00;
      st_nxt.step_clk = ~st_r.step_clk;
      step_rise = ~st_r.step_clk;
      step_fall = st_r.step_clk;
    end
    else
    begin
      st_nxt.step_div = st_r.step_div + 8'h01;
    end

    ss_tick = (st_r.cnt >= CNT_W'(SS_STEP_CYCLES - 1)); // see R11
    if (st_r.state == RSFS_RAMP_BOOT || st_r.state == RSFS_RAMP_CODE
        || st_r.state == RSFS_WAIT || st_r.state == RSFS_HOLD)
    begin
      st_nxt.cnt = st_r.cnt + 32'h1;
    end

    // Guard arming, fixed threshold before boot level
    st_nxt.ov_armed = supply_s & enable_s; // see R18
    if (st_r.ref_v >= REF_UV_ARM)
    begin
      st_nxt.uv_armed = 1'b1; // see R12
    end
    if (st_r.mask_cnt != 5'h00)
    begin
      st_nxt.mask_cnt = st_r.mask_cnt - 5'h01; // see R1
    end
    ov_hit = st_r.ov_armed && st_r.mask_cnt == 5'h00 && !st_r.stepping
             && (st_r.boot_reached ? ov_code_s : ov_fix_s); // see R12 R17
    uv_hit = st_r.uv_armed && st_r.mask_cnt == 5'h00 && !st_r.stepping
             && uv_s; // see R20
    hiz_hit = sn_s | gnd_s | oc_s; // see R22 R23 R25 R5

    // Sequencer
    unique case (st_r.state)
      RSFS_OFF:
      begin
        st_nxt.cnt = '0;
        if (supply_s && enable_s)
        begin
          st_nxt.state = RSFS_WAIT; // see R6
        end
      end
      RSFS_WAIT:
      begin
        if (st_r.cnt >= CNT_W'(DELAY_CYCLES - 1))
        begin
          st_nxt.state = RSFS_RAMP_BOOT; // see R7
          st_nxt.cnt = '0;
        end
      end
      RSFS_RAMP_BOOT:
      begin
        if (ss_tick)
        begin
          st_nxt.cnt = '0;
          if (st_r.ref_v < REF_BOOT)
          begin
            st_nxt.ref_v = st_r.ref_v + REF_STEP; // see R8
          end
          else
          begin
            st_nxt.state = RSFS_HOLD;
            st_nxt.boot_reached = 1'b1;
            st_nxt.pull = 1'b1; // see R14
          end
        end
      end
      RSFS_HOLD:
      begin
        if (st_r.cnt >= CNT_W'(HOLD_CYCLES - 1))
        begin
          st_nxt.cnt = '0;
          st_nxt.code_cur = st_r.code_s2; // see R8
          if (st_r.code_s2 == CODE_OFF)
          begin
            st_nxt.state = RSFS_LATCH; // see R13
            st_nxt.off_latch = 1'b1;
          end
          else
          begin
            st_nxt.state = RSFS_RAMP_CODE;
          end
        end
      end
      RSFS_RAMP_CODE:
      begin
        if (ss_tick)
        begin
          st_nxt.cnt = '0;
          if (st_r.ref_v < target)
          begin
            st_nxt.ref_v = st_r.ref_v + REF_STEP; // see R9
          end
          else if (st_r.ref_v > target)
          begin
            st_nxt.ref_v = st_r.ref_v - REF_STEP; // see R10
          end
          else
          begin
            st_nxt.state = RSFS_RUN;
            st_nxt.pg_oe = 1'b0; // see R15
          end
        end
      end
      RSFS_RUN:
      begin
        // Code-change detect on step rise, confirm on following fall
        if (step_rise && !st_r.stepping && st_r.code_s2 != st_r.code_cur)
        begin
          st_nxt.code_cand = st_r.code_s2; // see R2
          st_nxt.cand_valid = 1'b1;
        end
        if (step_fall && st_r.cand_valid)
        begin
          st_nxt.cand_valid = 1'b0;
          if (st_r.code_s2 == st_r.code_cand)
          begin
            st_nxt.code_cur = st_r.code_cand; // see R2
            st_nxt.stepping = 1'b1;
            st_nxt.step_phase = 1'b0;
            st_nxt.dynamic_code_transition = 1'b1;
          end
        end
        // One LSB every two step-clock cycles from next rise
        if (step_rise && st_r.stepping)
        begin
          st_nxt.step_phase = ~st_r.step_phase;
          if (!st_r.step_phase)
          begin
            if (st_r.ref_v < target)
            begin
              st_nxt.ref_v = st_r.ref_v + REF_STEP; // see R3 R4
            end
            else if (st_r.ref_v > target)
            begin
              st_nxt.ref_v = st_r.ref_v - REF_STEP; // see R3 R4
            end
            else
            begin
              st_nxt.stepping = 1'b0;
              st_nxt.dynamic_code_transition = 1'b0;
              st_nxt.mask_cnt = 5'(MASK_CYC); // see R1
            end
          end
        end
      end
      RSFS_LATCH:
      begin
        // Exit only by enable or supply cycling
        if (!supply_s || !enable_s)
        begin
          st_nxt = '0; // see R21
          // Synchronisers keep shifting through the restart
          st_nxt.sync1 = {gnd_amp_disc_cmp_in, sense_neg_disc_cmp_in, current_limit_cmp_in,
                          uv_cmp_in, ov_code_cmp_in, ov_fixed_cmp_in, enable_in,
                          supply_good_in}; // see R24
          st_nxt.sync2 = st_r.sync1; // see R24
          st_nxt.code_s1 = voltage_code_in;
          st_nxt.code_s2 = st_r.code_s1;
          st_nxt.pg_oe = 1'b1; // see R15
          st_nxt.state = RSFS_OFF;
          st_nxt.fault = RSFS_FLT_NONE;
        end
      end
      default:
      begin
        st_nxt.state = RSFS_OFF;
      end
    endcase

    // Enable loss outside a latch restarts the sequence
    if (st_r.state != RSFS_OFF && st_r.state != RSFS_LATCH && !(supply_s && enable_s))
    begin
      st_nxt.state = RSFS_OFF;
      st_nxt.ref_v = REF_ZERO;
      st_nxt.pg_oe = 1'b1;
      st_nxt.switching = 1'b0;
      st_nxt.pull = 1'b0;
      st_nxt.boot_reached = 1'b0;
      st_nxt.uv_armed = 1'b0;
      st_nxt.stepping = 1'b0;
      st_nxt.dynamic_code_transition = 1'b0;
      st_nxt.cand_valid = 1'b0;
    end
    else if (st_r.state != RSFS_OFF && st_r.state != RSFS_LATCH)
    begin
      // Protection latching, high-Z faults take priority
      if (hiz_hit)
      begin
        st_nxt.state = RSFS_LATCH; // see R22 R23 R25
        st_nxt.fault = RSFS_FLT_HIZ;
      end
      else if (ov_hit || uv_hit)
      begin
        st_nxt.state = RSFS_LATCH; // see R19 R20
        st_nxt.fault = RSFS_FLT_OV;
      end
    end

    // First modulation pulse ends low-side-free start
    if (st_r.state != RSFS_OFF && st_r.state != RSFS_LATCH && st_r.state != RSFS_WAIT
        && |pwm_in)
    begin
      st_nxt.switching = 1'b1; // see R16
    end

    // Output drive
    st_nxt.ph_out = pwm_in;
    st_nxt.ph_oe = {PHASES{st_nxt.switching}}; // see R16
    st_nxt.drv_en = st_nxt.switching; // see R16
    st_nxt.fault_output = 1'b0;
    if (st_nxt.state == RSFS_LATCH)
    begin
      st_nxt.pg_oe = 1'b1;
      st_nxt.fault_output = (st_nxt.fault != RSFS_FLT_NONE);
      st_nxt.ph_out = '0;
      st_nxt.ph_oe = '0;
      st_nxt.drv_en = 1'b0;
      if (st_nxt.fault == RSFS_FLT_OV)
      begin
        st_nxt.ph_oe = {PHASES{1'b1}}; // see R19 R17
        st_nxt.drv_en = 1'b1; // see R19
      end
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      st_r <= '0;
      st_r.pg_oe <= 1'b1; // Power good held low in reset
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign phase_modulation_output_out = st_r.ph_out;
  assign phase_modulation_oe_out = st_r.ph_oe;
  assign driver_enable_output_out = st_r.drv_en;
  assign fault_output_out = st_r.fault_output;
  assign power_good_oe_out = st_r.pg_oe;
  assign code_pull_enable_out = st_r.pull;
  assign dynamic_code_transition_out = st_r.dynamic_code_transition;
  assign reference_out = st_r.ref_v;
endmodule

// ==== tb/rsfs_sequencer_checker.sv ====
`timescale 1ns/1ps
// ==========================================================
// Port-level checker
module rsfs_sequencer_checker
  import rsfs_pkg::*;
#(
  parameter int DELAY_CYCLES = 50
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic supply_good_in,
  input wire logic enable_in,
  input wire logic [CODE_W-1:0] voltage_code_in,
  input wire logic [PHASES-1:0] pwm_in,
  input wire logic current_limit_cmp_in,
  input wire logic [PHASES-1:0] phase_modulation_output_out,
  input wire logic [PHASES-1:0] phase_modulation_oe_out,
  input wire logic driver_enable_output_out,
  input wire logic fault_output_out,
  input wire logic power_good_oe_out,
  input wire logic dynamic_code_transition_out,
  input wire logic [REF_W-1:0] reference_out
);
  int en_cnt;
  int quiet_cnt;

  // Cycles with start conditions held, cycles since a code step ended
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      en_cnt <= 0;
      quiet_cnt <= 31;
    end
    else
    begin
      en_cnt <= (enable_in && supply_good_in) ? en_cnt + 1 : 0;
      quiet_cnt <= dynamic_code_transition_out ? 0 : (quiet_cnt < 31 ? quiet_cnt + 1 : 31);
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  start_wait_a: assert property (
    $changed(reference_out) && $past(reference_out) == REF_ZERO |-> en_cnt >= DELAY_CYCLES)
    else $error("reference left zero before the start wait");
  ref_step_a: assert property (
    $changed(reference_out) && reference_out != REF_ZERO
    |-> reference_out == $past(reference_out) + REF_STEP
    || reference_out == $past(reference_out) - REF_STEP)
    else $error("reference moved by more than one step");
  ref_hold_a: assert property (
    $changed(reference_out) && reference_out != REF_ZERO
    |=> $stable(reference_out) || reference_out == REF_ZERO)
    else $error("reference stepped on consecutive cycles");
  phase_hiz_a: assert property (
    !driver_enable_output_out |-> phase_modulation_oe_out == '0)
    else $error("phases driven while drivers disabled");
  drv_pulse_a: assert property (
    $rose(driver_enable_output_out) && !fault_output_out
    |-> $past(|pwm_in) || $past(|pwm_in, 2))
    else $error("drivers enabled without a modulation pulse");
  ov_latch_a: assert property (
    fault_output_out && driver_enable_output_out
    |-> phase_modulation_output_out == '0 && phase_modulation_oe_out == '1)
    else $error("guard latch does not hold low sides on");
  oc_latch_a: assert property (
    $rose(current_limit_cmp_in) && !power_good_oe_out && enable_in && supply_good_in
    |-> ##[2:4] (fault_output_out && !driver_enable_output_out))
    else $error("current limit not latched in time");
  fault_keep_a: assert property (
    (enable_in && supply_good_in)[*4] ##0 fault_output_out |=> fault_output_out)
    else $error("fault released without enable cycle");
  pg_code_a: assert property (
    $fell(power_good_oe_out) |-> reference_out == voltage_code_in && !fault_output_out)
    else $error("power good released before the ramp ended");
  guard_mask_a: assert property (
    $rose(fault_output_out) && driver_enable_output_out |-> quiet_cnt >= MASK_CYC)
    else $error("guard fired inside the step mask");

  // Main scenarios reached
  cover property ($fell(power_good_oe_out));
  cover property ($fell(dynamic_code_transition_out));
  cover property ($rose(fault_output_out) && !driver_enable_output_out);
endmodule

bind rsfs_sequencer rsfs_sequencer_checker #(.DELAY_CYCLES(DELAY_CYCLES)) rsfs_sequencer_checker_i (.*);

// ==== tb/rsfs_partner.sv ====
`timescale 1ns/1ps
// ==========================================================
// Processor code lines and modulator pulses
module rsfs_partner
  import rsfs_pkg::*;
(
  input wire logic clk_in,
  input wire logic run_in,
  input wire logic [CODE_W-1:0] code_in,
  output logic [CODE_W-1:0] code_out,
  output logic [PHASES-1:0] pwm_out
);
  logic [2:0] tick_r = 3'h0;

  // Free-running modulator period
  always_ff @(posedge clk_in)
  begin
    tick_r <= tick_r + 3'h1;
  end

  // Processor drives the code; all phases pulse once a period when running
  assign code_out = code_in;
  assign pwm_out = (run_in && tick_r == 3'h7) ? '1 : '0;
endmodule

// ==== tb/rsfs_sequencer_bench.sv ====
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench
module rsfs_sequencer_bench;
  import rsfs_pkg::*;
  logic clk_in, reset_n_in, sup, en, run, drv, fault_output, pgo, pull, dyn;
  logic [5:0] cmp;
  logic [7:0] code, vcode, refv;
  logic [3:0] pwm, pmo, poe;
  int fails = 0;
  int checks = 0;

  rsfs_partner rsfs_partner_i (.clk_in(clk_in), .run_in(run), .code_in(code),
    .code_out(vcode), .pwm_out(pwm));
  rsfs_sequencer #(.DELAY_CYCLES(50), .HOLD_CYCLES(20), .SS_STEP_CYCLES(2)) rsfs_sequencer_i (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .supply_good_in(sup), .enable_in(en),
    .voltage_code_in(vcode), .pwm_in(pwm), .ov_fixed_cmp_in(cmp[0]), .ov_code_cmp_in(cmp[1]),
    .uv_cmp_in(cmp[2]), .current_limit_cmp_in(cmp[3]), .sense_neg_disc_cmp_in(cmp[4]),
    .gnd_amp_disc_cmp_in(cmp[5]), .phase_modulation_output_out(pmo),
    .phase_modulation_oe_out(poe), .driver_enable_output_out(drv), .fault_output_out(fault_output),
    .power_good_oe_out(pgo), .code_pull_enable_out(pull),
    .dynamic_code_transition_out(dyn), .reference_out(refv));

  // ==========================================================
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic wait_pg;
    repeat (3000) if (pgo !== 1'b0) @(posedge clk_in);
    chk(pgo, 1'b0);
  endtask

  task automatic wait_flt;
    repeat (10) if (fault_output !== 1'b1) @(posedge clk_in);
    chk(fault_output, 1'b1);
  endtask

  // Cycle enable, start up, guards pulsed early; fx raises the fixed guard
  task automatic st(input logic [7:0] c, input bit fx);
    @(posedge clk_in);
    en <= 1'b0;
    run <= 1'b0;
    cmp <= 6'h00;
    code <= c;
    cyc(5);
    en <= 1'b1;
    cmp[2:1] <= 2'h3;
    cyc(40);
    chk(refv, REF_ZERO);
    chk(poe, 4'h0);
    chk(drv, 1'b0);
    repeat (2000) if (refv !== 8'h40) @(posedge clk_in);
    cmp[2:1] <= 2'h0;
    if (fx)
    begin
      cmp[0] <= 1'b1;
      wait_flt();
      chk(pmo, 4'h0);
      chk(drv, 1'b1);
      return;
    end
    repeat (400) if (refv !== REF_BOOT - 8'h01) @(posedge clk_in);
    chk(pull, 1'b0);
    chk(fault_output, 1'b0);
    chk(pgo, 1'b1);
    repeat (20) if (pull !== 1'b1) @(posedge clk_in);
    chk(refv, REF_BOOT);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_supply;
    @(posedge clk_in);
    en <= 1'b1;
    cmp <= 6'h03;
    cyc(200);
    chk(refv, REF_ZERO);
    chk(fault_output, 1'b0);
    chk(pgo, 1'b1);
    sup <= 1'b1;
  endtask

  task automatic t_ov;
    st(8'hc0, 1'b0);
    wait_pg();
    chk(refv, 8'hc0);
    chk(drv, 1'b0);
    run <= 1'b1;
    cyc(20);
    chk(drv, 1'b1);
    chk(poe, 4'hf);
    cmp[1] <= 1'b1;
    wait_flt();
    chk(pmo, 4'h0);
    chk(poe, 4'hf);
    cmp[1] <= 1'b0;
    cyc(50);
    chk(fault_output, 1'b1);
  endtask

  task automatic t_dynamic_code_transition;
    int n;
    st(8'hc0, 1'b0);
    wait_pg();
    run <= 1'b1;
    code <= 8'hc4;
    cyc(3);
    code <= 8'hc0;
    cyc(300);
    chk(refv, 8'hc0);
    code <= 8'hc2;
    repeat (300) if (dyn !== 1'b1) @(posedge clk_in);
    cmp[2] <= 1'b1;
    repeat (500) if (refv !== 8'hc1) @(posedge clk_in);
    for (n = 0; n < 400 && refv !== 8'hc2; n++) @(posedge clk_in);
    chk(8'(n), 8'hc8);
    repeat (300) if (dyn !== 1'b0) @(posedge clk_in);
    cyc(5);
    cmp[2] <= 1'b0;
    cyc(20);
    chk(fault_output, 1'b0);
    cmp[2] <= 1'b1;
    wait_flt();
    chk(pmo, 4'h0);
  endtask

  task automatic t_hiz;
    for (int i = 3; i < 6; i++)
    begin
      st(8'hc0, 1'b0);
      wait_pg();
      run <= 1'b1;
      cyc(20);
      if (i == 3)
      begin
        code <= 8'hb8;
        repeat (300) if (dyn !== 1'b1) @(posedge clk_in);
      end
      cmp[i] <= 1'b1;
      wait_flt();
      chk(poe, 4'h0);
      chk(drv, 1'b0);
    end
  endtask

  task automatic t_low;
    st(8'h80, 1'b0);
    wait_pg();
    chk(refv, 8'h80);
    st(CODE_OFF, 1'b0);
    cyc(60);
    chk(fault_output, 1'b0);
    chk(poe, 4'h0);
    chk(pgo, 1'b1);
  endtask

  // ==========================================================
  // Clock, sequence and watchdog
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial
  begin
    reset_n_in = 1'b0;
    sup = 1'b0;
    en = 1'b0;
    run = 1'b0;
    cmp = 6'h00;
    code = 8'hc0;
    cyc(2);
    reset_n_in <= 1'b1;
    t_supply();
    t_ov();
    t_dynamic_code_transition();
    t_hiz();
    t_low();
    st(8'hc0, 1'b1);
    stop_test();
  end

  initial
  begin
    #500000;
    fails++;
    stop_test();
  end
endmodule
